// [common/mrh_pkg.sv]
// Shared constants and types for the multi-unit run/halt synchroniser.
// Assumes a 32-bit AXI4-Lite register port with a 4-bit byte address.
`default_nettype none

package mrh_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] CMD_ADDR = 4'h4;
  localparam logic [3:0] STAT_ADDR = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Command register bit positions
  // ----------------------------------------
  localparam int CMD_RUN = 0;
  localparam int CMD_GROUP_RUN = 1;
  localparam int CMD_TOTAL_RUN = 2;
  localparam int CMD_GROUP_HALT = 3;
  localparam int CMD_TOTAL_HALT = 4;
  localparam int CMD_SELECT = 5;
  localparam int CMD_SEL_LSB = 8;
  localparam int ID_W = 4;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ROLE_INDEPENDENT = 2'b00,
    ROLE_MASTER = 2'b01,
    ROLE_SLAVE = 2'b10
  } mrh_role_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } mrh_state_t;

  typedef enum logic [1:0] {
    LINE_LOW = 2'b00,
    LINE_RELEASED = 2'b01,
    LINE_HIGH = 2'b10
  } mrh_line_t;

  typedef struct packed {
    logic [3:0] unit_id;
    logic autopoll;
    logic start_sync;
    mrh_role_t role;
  } mrh_cfg_t;

  typedef struct packed {
    mrh_line_t line_cond;
    logic armed;
    logic held_line;
    logic first_stop;
    logic foreground;
    mrh_state_t state;
  } mrh_stat_t;

  localparam int CFG_W = 8;
  localparam mrh_cfg_t CFG_RST = '{unit_id: 4'h0, autopoll: 1'b0, start_sync: 1'b0, role: ROLE_INDEPENDENT};
  localparam logic LINE_SYNC_RST = 1'b0;

endpackage

`default_nettype wire

// [logic/mrh_line_sync.sv]
// Two-stage synchroniser for the shared wired run/halt line.
// Assumes the line level may change at any time relative to clk.
`timescale 1ns/100ps
`default_nettype none

module mrh_line_sync
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Line
  input wire logic line_in,
  output logic line_sync
);

  logic meta_r;

  // ----------------------------------------
  // Synchroniser stages
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= mrh_pkg::LINE_SYNC_RST;
      line_sync <= mrh_pkg::LINE_SYNC_RST;
    end
    else
    begin
      meta_r <= line_in;
      line_sync <= meta_r;
    end
  end

endmodule

`default_nettype wire

// [logic/mrh_run_halt.sv]
// Run/halt synchronisation for one emulator unit on a shared wired line.
// Assumes an AXI4-Lite master and an external pull-up resolving the line.
`timescale 1ns/100ps
`default_nettype none

module mrh_run_halt
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write
  input wire logic [mrh_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [mrh_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Processor halt causes
  input wire logic error_evt,
  input wire logic breakpoint_evt,
  input wire logic trace_full_evt,
  // Wired run/halt line
  input wire logic rh_line_i,
  output logic rh_line_o,
  output logic rh_line_oe,
  // Unit status
  output logic exec_run,
  output logic foreground,
  output logic status_report
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic is_connected(input mrh_pkg::mrh_cfg_t c);
    is_connected = (c.role != mrh_pkg::ROLE_INDEPENDENT);
  endfunction

  function automatic logic is_member(input mrh_pkg::mrh_cfg_t c);
    is_member = (c.role != mrh_pkg::ROLE_INDEPENDENT) || c.start_sync;
  endfunction

  function automatic logic is_waiter(input mrh_pkg::mrh_cfg_t c);
    is_waiter = (c.role == mrh_pkg::ROLE_SLAVE) || c.start_sync;
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  mrh_pkg::mrh_cfg_t cfg_r, cfg_nxt;
  mrh_pkg::mrh_state_t state_r, state_nxt;
  mrh_pkg::mrh_stat_t stat_w;
  logic aw_full_r, w_full_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic aw_full_nxt, w_full_nxt, bvalid_nxt, rvalid_nxt;
  logic [mrh_pkg::ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_r, rdata_nxt;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r, bresp_nxt, rresp_nxt;
  logic aw_take, w_take, wr_fire, ar_take, wr_ctrl, wr_cmd, wr_ok, rd_ok;
  logic line_hi, line_d_r, line_fall;
  logic armed_r, armed_nxt, held_r, held_nxt, first_r, first_nxt;
  logic fg_r, fg_nxt, report_r, report_nxt, line_oe_r, line_oe_nxt, run_r, zero_r;
  logic cmd_run, cmd_group_run_cmd, cmd_total_run_cmd, cmd_group_halt_cmd, cmd_total_halt_cmd, cmd_sel, sel_me, sel_other;
  logic member, waiter, slave_fall, halt_any, run_go, stop_evt;

  // ----------------------------------------
  // Line input synchroniser
  // ----------------------------------------
  mrh_line_sync u_sync
  (
    .clk(clk),
    .rst(rst),
    .line_in(rh_line_i),
    .line_sync(line_hi)
  );

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  assign aw_take = s_axi_awvalid && awready_r;
  assign w_take = s_axi_wvalid && wready_r;
  assign wr_fire = aw_full_r && w_full_r && !bvalid_r;
  assign ar_take = s_axi_arvalid && arready_r;
  assign aw_full_nxt = wr_fire ? 1'b0 : (aw_full_r || aw_take);
  assign w_full_nxt = wr_fire ? 1'b0 : (w_full_r || w_take);
  assign bvalid_nxt = wr_fire || (bvalid_r && !s_axi_bready);
  assign rvalid_nxt = ar_take || (rvalid_r && !s_axi_rready);
  assign wr_ctrl = wr_fire && (aw_addr_r == mrh_pkg::CTRL_ADDR) && w_strb_r[0];
  assign wr_cmd = wr_fire && (aw_addr_r == mrh_pkg::CMD_ADDR) && w_strb_r[0];
  assign wr_ok = (aw_addr_r == mrh_pkg::CTRL_ADDR) || (aw_addr_r == mrh_pkg::CMD_ADDR);
  assign bresp_nxt = wr_fire ? (wr_ok ? mrh_pkg::RESP_OKAY : mrh_pkg::RESP_SLVERR) : bresp_r;
  assign rd_ok = (s_axi_araddr == mrh_pkg::CTRL_ADDR) || (s_axi_araddr == mrh_pkg::CMD_ADDR)
    || (s_axi_araddr == mrh_pkg::STAT_ADDR);
  assign rdata_nxt = !ar_take ? rdata_r
    : (s_axi_araddr == mrh_pkg::CTRL_ADDR) ? {24'h000000, cfg_r}
    : (s_axi_araddr == mrh_pkg::STAT_ADDR) ? {24'h000000, stat_w} : 32'h00000000;
  assign rresp_nxt = !ar_take ? rresp_r : (rd_ok ? mrh_pkg::RESP_OKAY : mrh_pkg::RESP_SLVERR);
  assign cfg_nxt = wr_ctrl ? mrh_pkg::mrh_cfg_t'(w_data_r[mrh_pkg::CFG_W-1:0]) : cfg_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= mrh_pkg::RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= mrh_pkg::RESP_OKAY;
      rdata_r <= 32'h00000000;
      aw_addr_r <= 4'h0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      cfg_r <= mrh_pkg::CFG_RST;
    end
    else
    begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awready_r <= !aw_full_nxt && !bvalid_nxt;
      wready_r <= !w_full_nxt && !bvalid_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= !rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      aw_addr_r <= aw_take ? s_axi_awaddr : aw_addr_r;
      w_data_r <= w_take ? s_axi_wdata : w_data_r;
      w_strb_r <= w_take ? s_axi_wstrb : w_strb_r;
      cfg_r <= cfg_nxt;
    end
  end

  // ----------------------------------------
  // Commands and halt causes
  // ----------------------------------------
  assign cmd_run = wr_cmd && w_data_r[mrh_pkg::CMD_RUN];
  assign cmd_group_run_cmd = wr_cmd && w_data_r[mrh_pkg::CMD_GROUP_RUN];
  assign cmd_total_run_cmd = wr_cmd && w_data_r[mrh_pkg::CMD_TOTAL_RUN];
  assign cmd_group_halt_cmd = wr_cmd && w_data_r[mrh_pkg::CMD_GROUP_HALT];
  assign cmd_total_halt_cmd = wr_cmd && w_data_r[mrh_pkg::CMD_TOTAL_HALT];
  assign cmd_sel = wr_cmd && w_data_r[mrh_pkg::CMD_SELECT];
  assign sel_me = cmd_sel && (w_data_r[mrh_pkg::CMD_SEL_LSB +: mrh_pkg::ID_W] == cfg_r.unit_id);
  assign sel_other = cmd_sel && !sel_me;
  assign member = is_member(cfg_r);
  assign waiter = is_waiter(cfg_r);
  assign line_fall = line_d_r && !line_hi;
  assign slave_fall = (cfg_r.role == mrh_pkg::ROLE_SLAVE) && armed_r && line_fall;
  assign halt_any = sel_me || error_evt || breakpoint_evt || trace_full_evt
    || (cmd_group_halt_cmd && member) || cmd_total_halt_cmd || slave_fall;
  assign run_go = cmd_run || cmd_total_run_cmd || (cmd_group_run_cmd && member);

  // ----------------------------------------
  // Run state machine
  // ----------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      mrh_pkg::ST_IDLE:
      begin
        if (run_go && !halt_any)
        begin
          state_nxt = waiter ? mrh_pkg::ST_WAIT : mrh_pkg::ST_RUN;
        end
      end
      mrh_pkg::ST_WAIT:
      begin
        if (halt_any)
        begin
          state_nxt = mrh_pkg::ST_IDLE;
        end
        else if (line_hi)
        begin
          state_nxt = mrh_pkg::ST_RUN;
        end
      end
      mrh_pkg::ST_RUN:
      begin
        if (halt_any)
        begin
          state_nxt = mrh_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = mrh_pkg::ST_IDLE;
      end
    endcase
  end

  assign stop_evt = (state_r == mrh_pkg::ST_RUN) && (state_nxt == mrh_pkg::ST_IDLE);
  assign armed_nxt = (state_nxt == mrh_pkg::ST_RUN)
    && (armed_r || ((state_r == mrh_pkg::ST_WAIT) && (cfg_r.role == mrh_pkg::ROLE_SLAVE)));
  assign held_nxt = stop_evt ? line_hi : held_r;
  assign first_nxt = stop_evt ? line_hi
    : ((state_r == mrh_pkg::ST_IDLE) && (state_nxt != mrh_pkg::ST_IDLE)) ? 1'b0 : first_r;
  assign report_nxt = stop_evt && line_hi && cfg_r.autopoll;
  assign fg_nxt = (sel_me || report_nxt) ? 1'b1
    : (sel_other || (state_nxt != mrh_pkg::ST_IDLE)) ? 1'b0 : fg_r;
  assign line_oe_nxt = is_connected(cfg_nxt) && (state_nxt == mrh_pkg::ST_IDLE);
  assign stat_w.line_cond = line_oe_r ? mrh_pkg::LINE_LOW
    : (line_hi ? mrh_pkg::LINE_HIGH : mrh_pkg::LINE_RELEASED);
  assign stat_w.armed = armed_r;
  assign stat_w.held_line = held_r;
  assign stat_w.first_stop = first_r;
  assign stat_w.foreground = fg_r;
  assign stat_w.state = state_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= mrh_pkg::ST_IDLE;
      line_d_r <= mrh_pkg::LINE_SYNC_RST;
      armed_r <= 1'b0;
      held_r <= 1'b0;
      first_r <= 1'b0;
      fg_r <= 1'b0;
      report_r <= 1'b0;
      line_oe_r <= 1'b0;
      run_r <= 1'b0;
      zero_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      line_d_r <= line_hi;
      armed_r <= armed_nxt;
      held_r <= held_nxt;
      first_r <= first_nxt;
      fg_r <= fg_nxt;
      report_r <= report_nxt;
      line_oe_r <= line_oe_nxt;
      run_r <= (state_nxt == mrh_pkg::ST_RUN);
      zero_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign rh_line_o = zero_r;
  assign rh_line_oe = line_oe_r;
  assign exec_run = run_r;
  assign foreground = fg_r;
  assign status_report = report_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_run_releases_line: assert property (@(posedge clk) disable iff (rst)
    (state_r == mrh_pkg::ST_RUN) |-> !rh_line_oe) else $error("line driven while running");
  chk_idle_pulls_line: assert property (@(posedge clk) disable iff (rst)
    (state_r == mrh_pkg::ST_IDLE && cfg_r.role != mrh_pkg::ROLE_INDEPENDENT) |-> rh_line_oe)
    else $error("connected idle unit not pulling line");
  chk_wait_holds_low: assert property (@(posedge clk) disable iff (rst)
    (state_r == mrh_pkg::ST_WAIT && !line_hi) |=> (state_r != mrh_pkg::ST_RUN))
    else $error("started on low line");
  chk_wait_starts_high: assert property (@(posedge clk) disable iff (rst)
    (state_r == mrh_pkg::ST_WAIT && line_hi && !halt_any) |=> exec_run)
    else $error("waiting unit missed high line");
  chk_slave_fall_halts: assert property (@(posedge clk) disable iff (rst)
    (state_r == mrh_pkg::ST_RUN && cfg_r.role == mrh_pkg::ROLE_SLAVE && armed_r && $fell(line_hi))
    |=> (state_r == mrh_pkg::ST_IDLE)) else $error("slave ignored line fall");
  chk_master_keeps_run: assert property (@(posedge clk) disable iff (rst)
    (state_r == mrh_pkg::ST_RUN && cfg_r.role == mrh_pkg::ROLE_MASTER && !halt_any) |=> exec_run)
    else $error("master halted by line");
  chk_first_stop_flag: assert property (@(posedge clk) disable iff (rst)
    (stop_evt && line_hi) |=> (first_r && held_r) ##0 (status_report == $past(cfg_r.autopoll)))
    else $error("first stopper not flagged");
  chk_indep_ignores_group_run_cmd: assert property (@(posedge clk) disable iff (rst)
    (state_r == mrh_pkg::ST_IDLE && !member && !cmd_run && !cmd_total_run_cmd) |=> (state_r == mrh_pkg::ST_IDLE))
    else $error("non-member left idle");
  chk_total_run_direct: assert property (@(posedge clk) disable iff (rst)
    (state_r == mrh_pkg::ST_IDLE && cmd_total_run_cmd && !waiter && !halt_any) |=> exec_run)
    else $error("total run did not start unit");
  chk_total_halt_stops: assert property (@(posedge clk) disable iff (rst)
    (state_r != mrh_pkg::ST_IDLE && cmd_total_halt_cmd) |=> (state_r == mrh_pkg::ST_IDLE && !exec_run))
    else $error("total halt ignored");
  chk_select_foreground: assert property (@(posedge clk) disable iff (rst)
    sel_me |=> (foreground && !exec_run)) else $error("selected unit not in foreground");

endmodule

`default_nettype wire

// [tb/mrh_peer.sv]
// Behavioural model of another connected unit on the wired run/halt line.
// Assumes the bench pulses go and stop for one cycle and resolves the line.
`timescale 1ns/100ps
`default_nettype none

module mrh_peer
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Orders from the bench
  input wire logic go,
  input wire logic stop,
  // Wired line
  output logic pull_low
);
  logic run_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      run_r <= 1'b0;
    else if (stop)
      run_r <= 1'b0;
    else if (go)
      run_r <= 1'b1;
  end

  // The unit only ever pulls the line low, and does so while it is not running.
  assign pull_low = !run_r;
endmodule

`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for one run/halt unit beside a peer unit on the line.
// Assumes the register map and timing given with the design.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, oe, run, fg, rep, line, p_low, lo;
  logic [1:0] bresp, rresp, r, role;
  logic [2:0] cause = 3'h0;
  logic p_go = 1'b0, p_stop = 1'b0, rep_seen = 1'b0, sync;
  int n_fail = 0, comparisons = 0, cyc = 0, seed = 23;

  always #25 clk = ~clk;

  mrh_run_halt dut_u
  (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .error_evt(cause[2]), .breakpoint_evt(cause[1]), .trace_full_evt(cause[0]),
    .rh_line_i(line), .rh_line_o(lo), .rh_line_oe(oe),
    .exec_run(run), .foreground(fg), .status_report(rep)
  );

  mrh_peer peer_u (.clk(clk), .rst(rst), .go(p_go), .stop(p_stop), .pull_low(p_low));

  // Pull-up on the wired line; any unit pulling low wins.
  assign line = !(oe | p_low);

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (rep)
      rep_seen <= 1'b1;
    if (cyc == 5000)
    begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons = comparisons + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic peer(input logic g);
    @(posedge clk);
    p_go <= g;
    p_stop <= !g;
    @(posedge clk);
    p_go <= 1'b0;
    p_stop <= 1'b0;
    w(6);
  endtask

  function automatic logic member(input logic [1:0] ro, input logic s);
    return (ro != 2'h0) | s;
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    w(3);
    rst <= 1'b0;
    rd(mrh_pkg::CTRL_ADDR, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, mrh_pkg::RESP_OKAY});
    rd(4'hc, d, r);
    chk({30'h0, r}, {30'h0, mrh_pkg::RESP_SLVERR});
    wr(4'hc, 32'h1, r);
    chk({30'h0, r}, {30'h0, mrh_pkg::RESP_SLVERR});
    chkb(oe, 1'b0);
    for (int k = 0; k < 3; k++)
    begin
      wr(mrh_pkg::CMD_ADDR, 32'h1, r);
      w(6);
      chkb(run, 1'b1);
      chkb(oe, 1'b0);
      @(posedge clk);
      cause <= 3'(1 << k);
      @(posedge clk);
      cause <= 3'h0;
      w(4);
      chkb(run, 1'b0);
    end
    wr(mrh_pkg::CMD_ADDR, 32'h2, r);
    w(6);
    chkb(run, 1'b0);
    wr(mrh_pkg::CTRL_ADDR, 32'h2, r);
    chk({30'h0, r}, {30'h0, mrh_pkg::RESP_OKAY});
    w(2);
    chkb(oe, 1'b1);
    wr(mrh_pkg::CMD_ADDR, 32'h1, r);
    w(6);
    rd(mrh_pkg::STAT_ADDR, d, r);
    chk(d & 32'he3, 32'h41);
    chkb(oe, 1'b0);
    chkb(lo, 1'b0);
    peer(1'b1);
    chkb(run, 1'b1);
    rd(mrh_pkg::STAT_ADDR, d, r);
    chk(d & 32'he3, 32'ha2);
    peer(1'b0);
    chkb(run, 1'b0);
    chkb(oe, 1'b1);
    rd(mrh_pkg::STAT_ADDR, d, r);
    chk(d & 32'h18, 32'h0);
    wr(mrh_pkg::CTRL_ADDR, 32'h5d, r);
    wr(mrh_pkg::CMD_ADDR, 32'h1, r);
    w(6);
    chkb(run, 1'b0);
    peer(1'b1);
    chkb(run, 1'b1);
    peer(1'b0);
    chkb(run, 1'b1);
    peer(1'b1);
    rep_seen <= 1'b0;
    wr(mrh_pkg::CMD_ADDR, 32'h10, r);
    w(4);
    chkb(run, 1'b0);
    chkb(fg, 1'b1);
    chkb(rep_seen, 1'b1);
    rd(mrh_pkg::STAT_ADDR, d, r);
    chk(d & 32'h18, 32'h18);
    wr(mrh_pkg::CMD_ADDR, 32'h1, r);
    w(6);
    chkb(run, 1'b1);
    chkb(fg, 1'b0);
    wr(mrh_pkg::CMD_ADDR, 32'h520, r);
    w(4);
    chkb(fg, 1'b1);
    chkb(run, 1'b0);
    wr(mrh_pkg::CMD_ADDR, 32'h320, r);
    w(2);
    chkb(fg, 1'b0);
    for (int i = 0; i < 12; i++)
    begin
      role = 2'({$random(seed)} % 3);
      sync = 1'($random(seed));
      wr(mrh_pkg::CTRL_ADDR, {29'h0, sync, role}, r);
      wr(mrh_pkg::CMD_ADDR, i[0] ? 32'h4 : 32'h2, r);
      w(6);
      chkb(run, i[0] | member(role, sync));
      wr(mrh_pkg::CMD_ADDR, 32'h8, r);
      w(4);
      chkb(run, i[0] & !member(role, sync));
      wr(mrh_pkg::CMD_ADDR, 32'h10, r);
      w(4);
      chkb(run, 1'b0);
    end
    print_verdict();
  end
endmodule

`default_nettype wire
